// File: rtl/gtbp_pkg.sv
package gtbp_pkg;

   // ---------------------------------------------------------------
   // geometry
   // ---------------------------------------------------------------
   localparam int          GTBP_PINS_PER_BANK = 8;
   localparam int          GTBP_NUM_PINS      = 16;
   localparam int          GTBP_ADDR_W        = 4;
   localparam int          GTBP_DATA_W        = 32;

   // ---------------------------------------------------------------
   // register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [3:0]  GTBP_OFS_FIRST     = 4'h0;
   localparam logic [3:0]  GTBP_OFS_SECOND    = 4'h4;

   // field lsb positions inside a bank register
   localparam int          GTBP_FLD_FUNC      = 24;
   localparam int          GTBP_FLD_DIR       = 16;
   localparam int          GTBP_FLD_SPEC      = 8;
   localparam int          GTBP_FLD_DATA      = 0;

   // board pins in the second bank
   localparam int          GTBP_LAMP_BIT      = 6;
   localparam int          GTBP_BUTTON_BIT    = 5;

   // reset values: first bank all plain input, second bank lamp as lit output
   localparam logic [7:0]  GTBP_RST_FUNC      = 8'h00;
   localparam logic [7:0]  GTBP_RST_DIR_A     = 8'h00;
   localparam logic [7:0]  GTBP_RST_DIR_C     = 8'h40;
   localparam logic [7:0]  GTBP_RST_SPEC      = 8'h00;
   localparam logic [7:0]  GTBP_RST_DATA_C    = 8'h40;
   localparam logic [7:0]  GTBP_RST_DATA_A    = 8'h00;
   localparam logic [31:0] GTBP_RD_ZERO       = 32'h0000_0000;

   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [3:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } gtbp_req_t;

   typedef struct packed {
      logic [7:0] func;
      logic [7:0] dir;
      logic [7:0] spec;
      logic [7:0] data;
   } gtbp_bank_t;

   typedef struct packed {
      logic [15:0] o;
      logic [15:0] oe_n;
   } gtbp_pad_t;

endpackage : gtbp_pkg

// File: rtl/gtbp_pin_bank.sv
// one bank of eight pins: pad drive and pad level readback
module gtbp_pin_bank
   import gtbp_pkg::*;
#(
   parameter int  WIDTH    = 8,
   parameter bit  HAS_SPEC = 1'b1
) (
   input  wire gtbp_pkg::gtbp_bank_t i_cfg,
   input  wire logic [WIDTH-1:0]     i_pad,
   output logic [WIDTH-1:0]          o_pad,
   output logic [WIDTH-1:0]          o_pad_oe_n,
   output logic [WIDTH-1:0]          o_level
);

   // ---------------------------------------------------------------
   // per-pin decode
   // ---------------------------------------------------------------
   for (genvar g = 0; g < WIDTH; g++) begin : g_pin
      logic spec;
      assign spec = HAS_SPEC ? i_cfg.spec[g] : 1'b0;
      // drive only as plain output
      assign o_pad_oe_n[g] = ~(~i_cfg.func[g] & i_cfg.dir[g] & ~spec);
      assign o_pad[g]      = i_cfg.data[g];
      // readback is the pad level, whatever the mode
      assign o_level[g]    = i_pad[g];
   end

endmodule : gtbp_pin_bank

// File: rtl/gtbp_gpio.sv
module gtbp_gpio
   import gtbp_pkg::*;
(
   input  wire logic                   i_ref_clk,
   input  wire logic                   i_resetn,
   input  wire gtbp_pkg::gtbp_req_t    i_req,
   output logic [31:0]                 o_rdata,
   input  wire logic [15:0]            i_pad,
   output gtbp_pkg::gtbp_pad_t         o_pad
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      gtbp_bank_t  first;
      gtbp_bank_t  second;
      logic [31:0] rdata;
   } gtbp_state_t;

   gtbp_state_t state_q;
   gtbp_state_t state_d;
   logic [7:0]  level_a;
   logic [7:0]  level_c;
   logic [31:0] wd;

   assign wd = i_req.wdata;

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      state_d       = state_q;
      state_d.rdata = GTBP_RD_ZERO;
      // whole-word writes; software does read-modify-write
      if (i_req.wr && i_req.addr == GTBP_OFS_FIRST) begin
         state_d.first.func = wd[GTBP_FLD_FUNC +: GTBP_PINS_PER_BANK];
         state_d.first.dir  = wd[GTBP_FLD_DIR  +: GTBP_PINS_PER_BANK];
         state_d.first.spec = GTBP_RST_SPEC;
         state_d.first.data = wd[GTBP_FLD_DATA +: GTBP_PINS_PER_BANK];
      end
      if (i_req.wr && i_req.addr == GTBP_OFS_SECOND) begin
         state_d.second.func = wd[GTBP_FLD_FUNC +: GTBP_PINS_PER_BANK];
         state_d.second.dir  = wd[GTBP_FLD_DIR  +: GTBP_PINS_PER_BANK];
         state_d.second.spec = wd[GTBP_FLD_SPEC +: GTBP_PINS_PER_BANK];
         state_d.second.data = wd[GTBP_FLD_DATA +: GTBP_PINS_PER_BANK];
      end
      // read data: config plus live pad level, valid next cycle
      if (i_req.rd) begin
         unique case (i_req.addr)
            GTBP_OFS_FIRST: begin
               state_d.rdata = {state_q.first.func, state_q.first.dir,
                                state_q.first.spec, level_a};
            end
            GTBP_OFS_SECOND: begin
               state_d.rdata = {state_q.second.func, state_q.second.dir,
                                state_q.second.spec, level_c};
            end
            default: begin
               state_d.rdata = GTBP_RD_ZERO;                           // unmapped reads zero
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         state_q.first  <= '{GTBP_RST_FUNC, GTBP_RST_DIR_A, GTBP_RST_SPEC, GTBP_RST_DATA_A};
         // lamp comes up as lit plain output
         state_q.second <= '{GTBP_RST_FUNC, GTBP_RST_DIR_C, GTBP_RST_SPEC, GTBP_RST_DATA_C};
         state_q.rdata  <= GTBP_RD_ZERO;
      end else begin
         state_q <= state_d;
      end
   end

   assign o_rdata = state_q.rdata;

   // ---------------------------------------------------------------
   // pin banks
   // ---------------------------------------------------------------
   gtbp_pin_bank #(
      .WIDTH    (GTBP_PINS_PER_BANK),
      .HAS_SPEC (1'b0)
   ) u_first (
      .i_cfg      (state_q.first),
      .i_pad      (i_pad[7:0]),
      .o_pad      (o_pad.o[7:0]),
      .o_pad_oe_n (o_pad.oe_n[7:0]),
      .o_level    (level_a)
   );

   gtbp_pin_bank #(
      .WIDTH    (GTBP_PINS_PER_BANK),
      .HAS_SPEC (1'b1)
   ) u_second (
      .i_cfg      (state_q.second),
      .i_pad      (i_pad[15:8]),
      .o_pad      (o_pad.o[15:8]),
      .o_pad_oe_n (o_pad.oe_n[15:8]),
      .o_level    (level_c)
   );

endmodule : gtbp_gpio

// File: testbench/gtbp_gpio_properties.sv
module gtbp_chk
   import gtbp_pkg::*;
(
   input wire logic                i_ref_clk,
   input wire logic                i_resetn,
   input wire gtbp_pkg::gtbp_req_t i_req,
   input wire logic [31:0]         o_rdata,
   input wire logic [15:0]         i_pad,
   input wire gtbp_pkg::gtbp_pad_t o_pad
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_resetn);
   property p_idle; !i_req.rd |=> o_rdata == 32'h0000_0000; endproperty
   a_idle: assert property (p_idle) else $error("rdata not idle");
   property p_rda; i_req.rd && i_req.addr == 4'h0 |=> o_rdata[15:0] == {8'h00, $past(i_pad[7:0])}; endproperty
   a_rda: assert property (p_rda) else $error("bank a read");
   property p_rdc; i_req.rd && i_req.addr == 4'h4 |=> o_rdata[7:0] == $past(i_pad[15:8]); endproperty
   a_rdc: assert property (p_rdc) else $error("bank c read");
   property p_drva; i_req.wr && i_req.addr == 4'h0 && i_req.wdata[31:24] == 8'h00
      |=> o_pad.oe_n[7:0] == ~$past(i_req.wdata[23:16]); endproperty
   a_drva: assert property (p_drva) else $error("bank a drive");
   property p_drvc; i_req.wr && i_req.addr == 4'h4 && i_req.wdata[31:24] == 8'h00 && i_req.wdata[15:8] == 8'h00
      |=> o_pad.oe_n[15:8] == ~$past(i_req.wdata[23:16]); endproperty
   a_drvc: assert property (p_drvc) else $error("bank c drive");
   property p_mode; i_req.wr && i_req.addr == 4'h0 && i_req.wdata[31:24] == 8'hFF
      |=> o_pad.oe_n[7:0] == 8'hFF; endproperty
   a_mode: assert property (p_mode) else $error("non plain pin drives");
   property p_lamp; i_req.wr && i_req.addr == 4'h4
      |=> o_pad.oe_n[14] || o_pad.o[14] == $past(i_req.wdata[6]); endproperty
   a_lamp: assert property (p_lamp) else $error("lamp level");
   property p_keep; !(i_req.wr && i_req.addr[3] == 1'b0 && i_req.addr[1:0] == 2'b00) |=> $stable(o_pad); endproperty
   a_keep: assert property (p_keep) else $error("pads moved");
endmodule : gtbp_chk

bind gtbp_gpio gtbp_chk u_chk (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_req(i_req),
   .o_rdata(o_rdata), .i_pad(i_pad), .o_pad(o_pad));

// File: testbench/gtbp_pads_model.sv
// lamp and push button on the second bank
module gtbp_pads_model
   import gtbp_pkg::*;
(
   input  wire gtbp_pkg::gtbp_pad_t i_drv,
   input  wire logic                i_pressed,
   input  wire logic [15:0]         i_ext,
   output logic [15:0]              o_pad
);
   timeunit 1ns;
   timeprecision 1ps;
   // wire level: driver wins, lamp lit on high, button pulls up
   always_comb begin
      o_pad = i_ext;
      o_pad[13] = ~i_pressed;
      for (int i = 0; i < 16; i++)
         if (!i_drv.oe_n[i]) o_pad[i] = i_drv.o[i];
   end
endmodule : gtbp_pads_model

// File: testbench/gtbp_gpio_tb.sv
module gtbp_gpio_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import gtbp_pkg::*;
   logic        i_ref_clk = 1'b0;
   logic        i_resetn  = 1'b0;
   gtbp_req_t   req       = '0;
   logic [31:0] rdata;
   logic [15:0] pad;
   gtbp_pad_t   drv;
   logic        pressed   = 1'b0;
   int          fails     = 0;
   int          compares  = 0;
   always #2 i_ref_clk = ~i_ref_clk;
   gtbp_gpio u_dut (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_req(req), .o_rdata(rdata),
                    .i_pad(pad), .o_pad(drv));
   gtbp_pads_model u_pads (.i_drv(drv), .i_pressed(pressed), .i_ext(16'h00A5), .o_pad(pad));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %0t saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   // one bus cycle; read data sampled in the cycle after the strobe
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge i_ref_clk);
      req <= '{addr: a, wdata: d, wr: w, rd: !w};
      @(posedge i_ref_clk);
      req <= '0;
      #1;
   endtask : bus
   task automatic print_verdict;
      if (fails == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : print_verdict
   task automatic t_reset;
      check(drv.oe_n, 16'hBFFF);
      bus(1'b0, 4'h4, 32'h0);
      check(rdata, 32'h0040_0060);
      bus(1'b0, 4'h0, 32'h0);
      check(rdata, 32'h0000_00A5);
   endtask : t_reset
   task automatic t_bank_a;
      bus(1'b1, 4'h0, 32'h00FF_FF5A);
      check(drv.oe_n[7:0], 8'h00);
      check(drv.o[7:0], 8'h5A);
      bus(1'b0, 4'h0, 32'h0);
      check(rdata, 32'h00FF_005A);
      // function set with direction out: pins must stay released
      bus(1'b1, 4'h0, 32'hFFFF_00FF);
      check(drv.oe_n[7:0], 8'hFF);
      bus(1'b0, 4'h0, 32'h0);
      check(rdata, 32'hFFFF_00A5);
   endtask : t_bank_a
   task automatic t_lamp_button;
      logic [31:0] r;
      bus(1'b0, 4'h4, 32'h0);
      r = rdata;
      bus(1'b1, 4'h4, r & ~32'h0000_0040);
      check(pad[14], 1'b0);
      @(posedge i_ref_clk);
      pressed <= 1'b1;
      bus(1'b0, 4'h4, 32'h0);
      check(rdata, 32'h0040_0000);
      // special function on the button pin with direction out: no drive
      bus(1'b1, 4'h4, 32'h0060_2040);
      check(drv.oe_n[15:8], 8'hBF);
      // button back to plain input, lamp lit again
      bus(1'b1, 4'h4, 32'h0040_0040);
      check(pad[15:8], 8'h40);
   endtask : t_lamp_button
   task automatic t_unmapped;
      bus(1'b1, 4'h8, 32'hFFFF_FFFF);
      check(drv.oe_n, 16'hBFFF);
      bus(1'b0, 4'h8, 32'h0);
      check(rdata, 32'h0000_0000);
   endtask : t_unmapped
   initial begin
      repeat (16) @(posedge i_ref_clk);
      i_resetn <= 1'b1;
      t_reset();
      t_bank_a();
      t_lamp_button();
      t_unmapped();
      print_verdict();
   end
endmodule : gtbp_gpio_tb
